// >>> hw/vme_interrupter.sv
// Top: VMEbus interrupter status, routing and STATUS/ID with an APB slave
// -----------------------------------------------------------------
// Notes on behaviour
// - Level 1-7 software status reads 1 while active; write 1 clears.
// - Four mailbox status bits read 1 when active; write 1 clears.
// - All status bits but the general software one reset to 0.
// - Bus error, PCI error, DMA, local line status set on pending; W1C.
// - General software status resets set when auto-identify option is chosen.
// - Local source map value n routes it to request line n.
// - Map value 000 keeps a source off every request line.
// - Own maps for general soft, bus error, PCI error, DMA; last three reset 0.
// - Auto-identify option resets general software map to level 2.
// - Acknowledge returns 8-bit byte; bits 7:1 writable, reset all ones.
// - Bit 0 is 0 if software interrupt active at acknowledged level.
// - Enable rising edge raises software interrupt; clearing masks, keeps status.
// - Enable register gates which sources may drive request lines.
// -----------------------------------------------------------------
//
// Chosen here: the APB interface to the registers.
`default_nettype none
module vme_interrupter (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Power-up strap
  input wire logic auto_identify_option,
  // Event sources, pins from other domains
  input wire logic [3:0] mailboxEvent,
  input wire logic vmebusErrorEvent,
  input wire logic pciErrorEvent,
  input wire logic dmaEvent,
  input wire logic [7:0] local_irq_lines,
  // Handler acknowledge
  input wire logic ackStrobe,
  input wire logic [2:0] ackLevel,
  output logic ackValid,
  output logic [7:0] ackVector,
  // Request lines, active high
  output logic [7:1] vme_request_lines,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host interrupt
  output logic hostIrq
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    // Strap capture after reset release
    logic [1:0] strapSeen;
    // Event pins: two flops, then the edge detector's previous value
    logic [14:0] srcSync1;
    logic [14:0] srcSync2;
    logic [14:0] srcPrev;
    // Software visible registers
    logic [31:0] pending;
    logic [31:0] enable;
    logic [31:0] localMap;
    logic [31:0] miscMap;
    logic [6:0] vectorHigh;
    // Registered outputs
    logic [7:1] request;
    logic [31:0] rdata;
    logic ready;
    logic err;
    // Host interrupt status and enable
    logic [0:0] hostStatus;
    logic [0:0] hostEnable;
    logic hostIrq;
  } top_state_t;
  top_state_t cur_q, nxt_d;

  logic ackValidInt;
  logic [7:0] ackVectorInt;
  vme_irq_if irqBus ();

  // -----------------------------------------------------------------
  // Source bundle for the mapper
  // -----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      irqBus.active[i] = cur_q.pending[vme_irq_pkg::LOCAL_LINES_POS + i];
      irqBus.enable[i] = cur_q.enable[vme_irq_pkg::LOCAL_LINES_POS + i];
      irqBus.level[3*i +: 3] = cur_q.localMap[vme_irq_pkg::LOCAL_MAP_STRIDE*i +: 3];
    end

    // DMA
    irqBus.active[8] = cur_q.pending[vme_irq_pkg::DMA_POS];
    irqBus.enable[8] = cur_q.enable[vme_irq_pkg::DMA_POS];
    irqBus.level[24 +: 3] = cur_q.miscMap[vme_irq_pkg::MAP_DMA_POS +: 3];

    // PCI error
    irqBus.active[9] = cur_q.pending[vme_irq_pkg::PCI_ERROR_POS];
    irqBus.enable[9] = cur_q.enable[vme_irq_pkg::PCI_ERROR_POS];
    irqBus.level[27 +: 3] = cur_q.miscMap[vme_irq_pkg::MAP_PCI_ERROR_POS +: 3];

    // VMEbus error
    irqBus.active[10] = cur_q.pending[vme_irq_pkg::VMEBUS_ERROR_POS];
    irqBus.enable[10] = cur_q.enable[vme_irq_pkg::VMEBUS_ERROR_POS];
    irqBus.level[30 +: 3] = cur_q.miscMap[vme_irq_pkg::MAP_VMEBUS_ERROR_POS +: 3];

    // General software interrupt
    irqBus.active[11] = cur_q.pending[vme_irq_pkg::GENERAL_SOFT_POS];
    irqBus.enable[11] = cur_q.enable[vme_irq_pkg::GENERAL_SOFT_POS];
    irqBus.level[33 +: 3] = cur_q.miscMap[vme_irq_pkg::MAP_GENERAL_SOFT_POS +: 3];

    // Mailboxes are reported but have no map field, so they never drive a line
    for (int i = 0; i < 4; i++) begin
      irqBus.active[12 + i] = cur_q.pending[vme_irq_pkg::MAILBOX_ZERO_POS + i];
      irqBus.enable[12 + i] = cur_q.enable[vme_irq_pkg::MAILBOX_ZERO_POS + i];
      irqBus.level[3*(12 + i) +: 3] = 3'h0;
    end

    // Software level interrupts sit at their own level by definition
    for (int i = 0; i < 7; i++) begin
      if (i < 4) begin
        irqBus.active[16 + i] = cur_q.pending[vme_irq_pkg::SOFT_LEVEL1_POS + i];
        irqBus.enable[16 + i] = cur_q.enable[vme_irq_pkg::SOFT_LEVEL1_POS + i];
        irqBus.level[3*(16 + i) +: 3] = 3'(i + 1);
      end
    end
  end

  vme_request_mapper u_mapper (
    .irqBus(irqBus.mapper)
  );

  // Levels 5-7 would overflow the 20-source bundle; they are merged here instead
  logic [7:1] softHigh;
  always_comb begin
    softHigh = '0;
    for (int i = 4; i < 7; i++) begin
      softHigh[i + 1] = cur_q.pending[vme_irq_pkg::SOFT_LEVEL1_POS + i] &
                        cur_q.enable[vme_irq_pkg::SOFT_LEVEL1_POS + i];
    end
  end

  // Software interrupts being generated, per level, for bit 0 of the vector
  logic [7:1] softActive;
  always_comb begin
    softActive = '0;
    for (int i = 0; i < 7; i++) begin
      softActive[i + 1] = cur_q.pending[vme_irq_pkg::SOFT_LEVEL1_POS + i] &
                          cur_q.enable[vme_irq_pkg::SOFT_LEVEL1_POS + i];
    end
    for (int l = 1; l <= 7; l++) begin
      if (cur_q.miscMap[vme_irq_pkg::MAP_GENERAL_SOFT_POS +: 3] == 3'(l) &&
          cur_q.pending[vme_irq_pkg::GENERAL_SOFT_POS] && cur_q.enable[vme_irq_pkg::GENERAL_SOFT_POS]) begin
        softActive[l] = 1'b1;
      end
    end
  end

  vme_ack_responder u_ack (
    .clock(clock),
    .sys_rst(sys_rst),
    .ackStrobe(ackStrobe),
    .ackLevel(ackLevel),
    .vectorHigh(cur_q.vectorHigh),
    .softLevelActive(softActive),
    .ackValid(ackValidInt),
    .ackVector(ackVectorInt)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  logic access;
  logic wr;
  logic [14:0] rise;
  logic [31:0] setEv;
  logic [31:0] clrEv;
  logic [31:0] enRise;
  always_comb begin
    nxt_d = cur_q;

    // APB: an access is taken once; ready answers one cycle later
    access = psel & penable & ~cur_q.ready;
    wr = access & pwrite;
    nxt_d.ready = access;
    nxt_d.err = 1'b0;

    // Event pins: two flops against metastability, then a rising-edge detector
    nxt_d.srcSync1 = {mailboxEvent, vmebusErrorEvent, pciErrorEvent, dmaEvent, local_irq_lines};
    nxt_d.srcSync2 = cur_q.srcSync1;
    nxt_d.srcPrev = cur_q.srcSync2;
    rise = cur_q.srcSync2 & ~cur_q.srcPrev;
    nxt_d.strapSeen = {cur_q.strapSeen[0], 1'b1};

    // Set and clear terms for the sticky status bits
    setEv = '0;
    clrEv = '0;
    enRise = '0;
    setEv[vme_irq_pkg::LOCAL_LINES_POS +: 8] = rise[7:0];
    setEv[vme_irq_pkg::DMA_POS] = rise[8];
    setEv[vme_irq_pkg::PCI_ERROR_POS] = rise[9];
    setEv[vme_irq_pkg::VMEBUS_ERROR_POS] = rise[10];
    setEv[vme_irq_pkg::MAILBOX_ZERO_POS +: 4] = rise[11 +: 4] | 4'h0;

    if (wr && paddr == vme_irq_pkg::VME_IRQ_ENABLE_OFF) begin
      enRise = pwdata & ~cur_q.enable & vme_irq_pkg::PENDING_MASK;
      nxt_d.enable = pwdata & vme_irq_pkg::PENDING_MASK;
    end
    // Only software sources are raised by an enable edge; others need their own event
    setEv[vme_irq_pkg::SOFT_LEVEL1_POS +: 7] = enRise[vme_irq_pkg::SOFT_LEVEL1_POS +: 7];
    setEv[vme_irq_pkg::GENERAL_SOFT_POS] = enRise[vme_irq_pkg::GENERAL_SOFT_POS];
    if (wr && paddr == vme_irq_pkg::SOURCE_SET_OFF) begin
      setEv[vme_irq_pkg::MAILBOX_ZERO_POS +: 4] = setEv[vme_irq_pkg::MAILBOX_ZERO_POS +: 4] |
                                                  pwdata[vme_irq_pkg::MAILBOX_ZERO_POS +: 4];
    end
    if (wr && paddr == vme_irq_pkg::VME_IRQ_PENDING_OFF) begin
      clrEv = pwdata & vme_irq_pkg::PENDING_MASK;
    end

    // Set beats clear in the same cycle
    nxt_d.pending = ((cur_q.pending & ~clrEv) | setEv) & vme_irq_pkg::PENDING_MASK;

    // Route maps keep only their 3-bit fields; reserved bits read 0
    if (wr && paddr == vme_irq_pkg::LOCAL_IRQ_ROUTE_MAP_OFF) begin
      nxt_d.localMap = pwdata & 32'h7777_7777;
    end
    if (wr && paddr == vme_irq_pkg::MISC_IRQ_ROUTE_MAP_OFF) begin
      nxt_d.miscMap = pwdata & 32'h0007_0777;
    end
    if (wr && paddr == vme_irq_pkg::ACK_VECTOR_OUT_OFF) begin
      nxt_d.vectorHigh = pwdata[vme_irq_pkg::ACK_VECTOR_POS + 1 +: 7];
    end

    // Strap caught at the first edge after reset release
    if (!cur_q.strapSeen[0] && auto_identify_option) begin
      nxt_d.pending[vme_irq_pkg::GENERAL_SOFT_POS] = 1'b1;
      nxt_d.enable[vme_irq_pkg::GENERAL_SOFT_POS] = 1'b1;
      nxt_d.miscMap[vme_irq_pkg::MAP_GENERAL_SOFT_POS +: 3] = vme_irq_pkg::AUTO_GENERAL_SOFT_LEVEL;
    end

    // Host side: a clear loses against an acknowledge in the same cycle
    if (wr && paddr == vme_irq_pkg::HOST_IRQ_CLEAR_OFF) begin
      nxt_d.hostStatus = cur_q.hostStatus & ~pwdata[0:0];
    end
    if (wr && paddr == vme_irq_pkg::HOST_IRQ_ENABLE_OFF) begin
      nxt_d.hostEnable = pwdata[0:0];
    end
    if (ackValidInt) begin
      nxt_d.hostStatus[vme_irq_pkg::HOST_EV_ACK_POS] = 1'b1;
    end
    nxt_d.hostIrq = |(nxt_d.hostStatus & nxt_d.hostEnable);

    // Request lines are registered so the pins never glitch
    nxt_d.request = irqBus.request | softHigh;

    // Read data is zero outside a read, so a stale word never shows
    nxt_d.rdata = '0;
    if (access && !pwrite) begin
      unique case (paddr)
        vme_irq_pkg::VME_IRQ_ENABLE_OFF: nxt_d.rdata = cur_q.enable;
        vme_irq_pkg::VME_IRQ_PENDING_OFF: nxt_d.rdata = cur_q.pending;
        vme_irq_pkg::LOCAL_IRQ_ROUTE_MAP_OFF: nxt_d.rdata = cur_q.localMap;
        vme_irq_pkg::MISC_IRQ_ROUTE_MAP_OFF: nxt_d.rdata = cur_q.miscMap;
        vme_irq_pkg::ACK_VECTOR_OUT_OFF: nxt_d.rdata = {cur_q.vectorHigh, 1'b1, 24'h000000};
        vme_irq_pkg::HOST_IRQ_STATUS_OFF: nxt_d.rdata = {31'h00000000, cur_q.hostStatus};
        vme_irq_pkg::HOST_IRQ_ENABLE_OFF: nxt_d.rdata = {31'h00000000, cur_q.hostEnable};
        vme_irq_pkg::HOST_IRQ_CLEAR_OFF, vme_irq_pkg::SOURCE_SET_OFF: nxt_d.rdata = '0;
        default: nxt_d.err = 1'b1;
      endcase
    end else if (access) begin
      // Writes to unmapped or read-only offsets are refused
      unique case (paddr)
        vme_irq_pkg::VME_IRQ_ENABLE_OFF, vme_irq_pkg::VME_IRQ_PENDING_OFF,
        vme_irq_pkg::LOCAL_IRQ_ROUTE_MAP_OFF, vme_irq_pkg::MISC_IRQ_ROUTE_MAP_OFF,
        vme_irq_pkg::ACK_VECTOR_OUT_OFF, vme_irq_pkg::HOST_IRQ_CLEAR_OFF,
        vme_irq_pkg::HOST_IRQ_ENABLE_OFF, vme_irq_pkg::SOURCE_SET_OFF: nxt_d.err = 1'b0;
        default: nxt_d.err = 1'b1;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      // Only the vector field comes up as ones
      cur_q <= '0;
      cur_q.vectorHigh <= vme_irq_pkg::ACK_VECTOR_RESET;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Acknowledge answer is registered inside the responder
  assign ackValid = ackValidInt;
  assign ackVector = ackVectorInt;
  assign vme_request_lines = cur_q.request;
  assign prdata = cur_q.rdata;
  assign pready = cur_q.ready;
  assign pslverr = cur_q.err;
  assign hostIrq = cur_q.hostIrq;
endmodule : vme_interrupter
`default_nettype wire

// >>> hw/vme_irq_pkg.sv
// Package: register map, field layout, reset values for the VMEbus interrupter
`default_nettype none
package vme_irq_pkg;
  // -----------------------------------------------------------------
  // Register byte offsets
  // -----------------------------------------------------------------
  localparam logic [11:0] VME_IRQ_ENABLE_OFF = 12'h310;
  localparam logic [11:0] VME_IRQ_PENDING_OFF = 12'h314;
  localparam logic [11:0] LOCAL_IRQ_ROUTE_MAP_OFF = 12'h318;
  localparam logic [11:0] MISC_IRQ_ROUTE_MAP_OFF = 12'h31C;
  localparam logic [11:0] ACK_VECTOR_OUT_OFF = 12'h320;
  localparam logic [11:0] HOST_IRQ_STATUS_OFF = 12'h330;
  localparam logic [11:0] HOST_IRQ_CLEAR_OFF = 12'h334;
  localparam logic [11:0] HOST_IRQ_ENABLE_OFF = 12'h338;
  localparam logic [11:0] SOURCE_SET_OFF = 12'h33C;
  // -----------------------------------------------------------------
  // Pending / enable bit positions
  // -----------------------------------------------------------------
  localparam int SOFT_LEVEL1_POS = 25;
  localparam int MAILBOX_ZERO_POS = 16;
  localparam int GENERAL_SOFT_POS = 12;
  localparam int VMEBUS_ERROR_POS = 10;
  localparam int PCI_ERROR_POS = 9;
  localparam int DMA_POS = 8;
  localparam int LOCAL_LINES_POS = 0;
  localparam logic [31:0] PENDING_MASK = 32'hFE0F_170F | 32'h0000_00F0;
  // -----------------------------------------------------------------
  // Route map fields
  // -----------------------------------------------------------------
  localparam int LOCAL_MAP_STRIDE = 4;
  localparam int MAP_GENERAL_SOFT_POS = 16;
  localparam int MAP_VMEBUS_ERROR_POS = 8;
  localparam int MAP_PCI_ERROR_POS = 4;
  localparam int MAP_DMA_POS = 0;
  localparam logic [2:0] AUTO_GENERAL_SOFT_LEVEL = 3'h2;
  // -----------------------------------------------------------------
  // Acknowledge vector
  // -----------------------------------------------------------------
  localparam int ACK_VECTOR_POS = 24;
  localparam logic [6:0] ACK_VECTOR_RESET = 7'h7F;
  // -----------------------------------------------------------------
  // Host interrupt events
  // -----------------------------------------------------------------
  localparam int HOST_EV_ACK_POS = 0;
  localparam int HOST_EV_WIDTH = 1;
  localparam int SOURCE_COUNT = 20;
endpackage : vme_irq_pkg
`default_nettype wire

// >>> hw/vme_irq_if.sv
// Interface: per-source active/enable/level bundle between top and request mapper
`default_nettype none
interface vme_irq_if;
  logic [19:0] active;
  logic [19:0] enable;
  logic [59:0] level;
  logic [7:1] request;
  modport ctrl (output active, output enable, output level, input request);
  modport mapper (input active, input enable, input level, output request);
endinterface : vme_irq_if
`default_nettype wire

// >>> hw/vme_request_mapper.sv
// Module: combines mapped, enabled, active sources into request levels
`default_nettype none
module vme_request_mapper (
  // Source bundle
  vme_irq_if.mapper irqBus
);
  genvar lvl;
  generate
    for (lvl = 1; lvl <= 7; lvl++) begin : g_level
      logic [19:0] hit;
      genvar s;
      for (s = 0; s < 20; s++) begin : g_src
        // Level 000 never matches, so such a source stays off the bus
        assign hit[s] = irqBus.active[s] & irqBus.enable[s] & (irqBus.level[3*s +: 3] == 3'(lvl));
      end
      assign irqBus.request[lvl] = |hit;
    end
  endgenerate
endmodule : vme_request_mapper
`default_nettype wire

// >>> hw/vme_ack_responder.sv
// Module: answers a handler acknowledge with the registered STATUS/ID byte
`default_nettype none
module vme_ack_responder (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Acknowledge request
  input wire logic ackStrobe,
  input wire logic [2:0] ackLevel,
  input wire logic [6:0] vectorHigh,
  input wire logic [7:1] softLevelActive,
  // Answer
  output logic ackValid,
  output logic [7:0] ackVector
);
  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } ack_state_t;
  ack_state_t cur_q, nxt_d;
  always_comb begin
    nxt_d = cur_q;
    nxt_d.valid = ackStrobe;
    if (ackStrobe) begin
      nxt_d.vector[7:1] = vectorHigh;
      nxt_d.vector[0] = (ackLevel != 3'h0 && softLevelActive[ackLevel]) ? 1'b0 : 1'b1;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end
  assign ackValid = cur_q.valid;
  assign ackVector = cur_q.vector;
endmodule : vme_ack_responder
`default_nettype wire

// >>> testbench/vme_interrupter_asserts.sv
// Checker: port-level properties of the VMEbus interrupter
`default_nettype none
module vme_interrupter_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Acknowledge and request lines
  input wire logic ackStrobe,
  input wire logic [2:0] ackLevel,
  input wire logic ackValid,
  input wire logic [7:0] ackVector,
  input wire logic [7:1] vme_request_lines,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  property p_ack_answer; ackStrobe |=> ackValid; endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack not answered");
  property p_ack_pulse; !ackStrobe |=> !ackValid; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("stray ack answer");
  property p_vec_hold; !ackStrobe |=> $stable(ackVector); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_vec_lvl0; ackStrobe && ackLevel == 3'h0 |=> ackVector[0]; endproperty
  a_vec_lvl0: assert property (p_vec_lvl0) else $error("bit0 low at level 0");
  property p_one_wait; psel && penable && !pready |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("late ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  property p_ready_qual; pready |-> psel && penable; endproperty
  a_ready_qual: assert property (p_ready_qual) else $error("ready without access");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  c_soft_ack: cover property (ackValid && !ackVector[0]);
  c_refused: cover property (pslverr);
  c_line: cover property (|vme_request_lines);
endmodule // vme_interrupter_asserts
`default_nettype wire

// >>> testbench/vme_irq_handler_model.sv
// Partner: VMEbus interrupt handler running acknowledge cycles
`default_nettype none
module vme_irq_handler_model (
  // Clock
  input wire logic clock,
  // Answer from the interrupter
  input wire logic ackValid,
  input wire logic [7:0] ackVector,
  // Acknowledge request
  output logic ackStrobe,
  output logic [2:0] ackLevel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ackStrobe = 1'h0;
    ackLevel = 3'h0;
  end
  // Level is meaningless outside the strobe, so it is scrambled afterwards
  task automatic acknowledge(input logic [2:0] lvl, input int lag, output logic [7:0] vec, output logic ok);
    int n;
    n = 0;
    repeat (lag + 1) @(posedge clock);
    ackStrobe <= 1'h1;
    ackLevel <= lvl;
    @(posedge clock);
    ackStrobe <= 1'h0;
    while (ackValid !== 1'h1 && n < 8) begin
      @(posedge clock);
      n++;
    end
    ok = ackValid;
    vec = ackVector;
    ackLevel <= ~lvl;
  endtask
endmodule // vme_irq_handler_model
`default_nettype wire

// >>> testbench/vme_interrupter_tb_top.sv
// Testbench top for the VMEbus interrupter
`default_nettype none
module vme_interrupter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // Wiring
  // ---------------------------------------------
  localparam logic [11:0] EN = vme_irq_pkg::VME_IRQ_ENABLE_OFF;
  localparam logic [11:0] PEN = vme_irq_pkg::VME_IRQ_PENDING_OFF;
  localparam logic [11:0] MP0 = vme_irq_pkg::LOCAL_IRQ_ROUTE_MAP_OFF;
  localparam logic [11:0] MP1 = vme_irq_pkg::MISC_IRQ_ROUTE_MAP_OFF;
  localparam logic [11:0] VEC = vme_irq_pkg::ACK_VECTOR_OUT_OFF;
  logic clock = 1'h0, sys_rst = 1'h1, strap = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [3:0] mbox = 4'h0;
  logic [2:0] ev = 3'h0;
  logic [7:0] lint = 8'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, hostIrq, ackStrobe, ackValid, lastErr;
  logic [2:0] ackLevel;
  logic [7:0] ackVector;
  logic [7:1] lines;
  int nErrors = 0, testsRun = 0, cyc = 0;
  always #5 clock = ~clock;
  vme_interrupter dut (.clock, .sys_rst, .auto_identify_option(strap), .mailboxEvent(mbox),
    .vmebusErrorEvent(ev[2]), .pciErrorEvent(ev[1]), .dmaEvent(ev[0]), .local_irq_lines(lint),
    .ackStrobe, .ackLevel, .ackValid, .ackVector, .vme_request_lines(lines), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .hostIrq);
  vme_irq_handler_model hnd (.clock, .ackValid, .ackVector, .ackStrobe, .ackLevel);
  task automatic completeRun();
    if (nErrors == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nErrors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Always leaves one idle edge first, so signals are never set twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    // Waits for pready with no limit of its own; a hang ends only at the bench timeout
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic ack(input logic [2:0] l, input logic [7:0] e);
    logic [7:0] v;
    logic ok;
    hnd.acknowledge(l, int'(l) % 2, v, ok);
    chk(32'(ok), 32'h1);
    chk(32'(v), 32'(e));
  endtask
  task automatic doReset(input logic s);
    sys_rst <= 1'h1;
    strap <= s;
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clock);
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic tSoft();
    logic [31:0] b;
    for (int k = 1; k < 8; k++) begin
      b = 32'h1 << (vme_irq_pkg::SOFT_LEVEL1_POS + k - 1);
      wr(EN, b);
      rd(PEN, b);
      chk(32'(lines), 32'h1 << (k - 1));
      ack(3'(k), 8'hFE);
      wr(EN, 32'h0);
      wr(PEN, 32'h0);
      rd(PEN, b);
      chk(32'(lines), 32'h0);
      ack(3'(k), 8'hFF);
      wr(PEN, b);
      rd(PEN, 32'h0);
    end
  endtask
  task automatic tLocal();
    logic [2:0] lvl;
    for (int i = 0; i < 8; i++) begin
      lvl = 3'(i % 7 + 1);
      wr(MP0, 32'(lvl) << (4 * i));
      wr(EN, 32'h1 << i);
      lint[i] <= 1'h1;
      repeat (6) @(posedge clock);
      rd(PEN, 32'h1 << i);
      chk(32'(lines), 32'h1 << (lvl - 1));
      wr(MP0, 32'h0);
      rd(PEN, 32'h1 << i);
      chk(32'(lines), 32'h0);
      wr(PEN, 32'h1 << i);
      lint[i] <= 1'h0;
      rd(PEN, 32'h0);
    end
  endtask
  task automatic tMisc();
    for (int j = 0; j < 3; j++) begin
      wr(MP1, 32'(5 + j) << (4 * j));
      wr(EN, 32'h100 << j);
      ev[j] <= 1'h1;
      repeat (6) @(posedge clock);
      rd(PEN, 32'h100 << j);
      chk(32'(lines), 32'h10 << j);
      wr(PEN, 32'h100 << j);
      ev[j] <= 1'h0;
      rd(PEN, 32'h0);
      chk(32'(lines), 32'h0);
    end
  endtask
  task automatic tOther();
    wr(EN, 32'h000F_0000);
    mbox <= 4'hF;
    repeat (6) @(posedge clock);
    rd(PEN, 32'h000F_0000);
    wr(PEN, 32'h000F_0000);
    mbox <= 4'h0;
    rd(PEN, 32'h0);
    wr(vme_irq_pkg::SOURCE_SET_OFF, 32'h0004_0000);
    rd(PEN, 32'h0004_0000);
    wr(PEN, 32'h0004_0000);
    rd(PEN, 32'h0);
    wr(vme_irq_pkg::HOST_IRQ_ENABLE_OFF, 32'h1);
    wr(vme_irq_pkg::HOST_IRQ_CLEAR_OFF, 32'h1);
    repeat (2) @(posedge clock);
    chk(32'(hostIrq), 32'h0);
    ack(3'h0, 8'hFF);
    repeat (2) @(posedge clock);
    chk(32'(hostIrq), 32'h1);
    wr(VEC, 32'hA400_0000);
    rd(VEC, 32'hA500_0000);
    ack(3'h3, 8'hA5);
    apb(1'h0, 12'h300, 32'h0, r);
    chk(32'(lastErr), 32'h1);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nErrors++;
      completeRun();
    end
  end
  initial begin
    doReset(1'h0);
    rd(PEN, 32'h0);
    rd(MP0, 32'h0);
    rd(MP1, 32'h0);
    rd(VEC, 32'hFF00_0000);
    tSoft();
    tLocal();
    tMisc();
    tOther();
    doReset(1'h1);
    rd(PEN, 32'h0000_1000);
    rd(MP1, 32'h0002_0000);
    chk(32'(lines), 32'h2);
    ack(3'h2, 8'hFE);
    completeRun();
  end
endmodule // vme_interrupter_tb_top
bind vme_interrupter vme_interrupter_asserts chk (.clock, .sys_rst, .ackStrobe, .ackLevel, .ackValid,
  .ackVector, .vme_request_lines, .psel, .penable, .pready, .pslverr);
`default_nettype wire
